// [hw/arinc_map_pkg.sv]
`default_nettype none
package arinc_map_pkg;
    // ==========================================
    // address fields
    localparam int            ADDR_W       = 9;
    localparam int            REG_IDX_LSB  = 2;
    localparam int            BLOCK_BIT    = 4;
    localparam int            CHAN_LSB     = 5;
    localparam int            CHAN_W       = 4;
    localparam logic [1:0]    REG_DATA     = 2'h0;
    localparam logic [1:0]    REG_CONTROL  = 2'h1;
    localparam logic [1:0]    REG_STATUS   = 2'h2;
    localparam logic [1:0]    REG_LABEL    = 2'h3;
    localparam logic          BLOCK_RX     = 1'h0;
    localparam logic          BLOCK_TX     = 1'h1;
    // ==========================================
    // control and status fields
    localparam int            RX_CTRL_W    = 8;
    localparam int            TX_CTRL_W    = 4;
    localparam logic [7:0]    RX_CTRL_RST  = 8'h00;
    localparam logic [3:0]    TX_CTRL_RST  = 4'h0;
    localparam int            CTL_RATE     = 0;
    localparam int            CTL_LBL_CMP  = 1;
    localparam int            CTL_LOOPBACK = 1;
    localparam int            CTL_PAR_EN   = 2;
    localparam int            CTL_PAR_EVEN = 3;
    localparam int            CTL_SDI_EN   = 4;
    localparam int            CTL_SDI_LSB  = 5;
    localparam int            CTL_RELOAD   = 7;
    localparam int            STAT_W       = 3;
    // ==========================================
    // word layout
    localparam int            WORD_W       = 32;
    localparam int            LABEL_W      = 8;
    localparam int            LABEL_LSB    = 0;
    localparam int            SDI_LSB      = 8;
    localparam int            SDI_W        = 2;
    localparam logic [7:0]    LABEL_RST    = 8'h00;
    localparam logic [31:0]   WORD_RST     = 32'h00000000;
    // ==========================================
    // host access sequence
    typedef enum logic [1:0] {ACC_IDLE, ACC_HOLD, ACC_DONE} access_state_type;
endpackage : arinc_map_pkg
`default_nettype wire

// [hw/word_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module word_fifo
    import arinc_map_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int LEVEL = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic                  empty,
    output logic                  at_level,
    output logic                  full
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             push_ok;
    logic             pop_ok;

    assign push_ok    = push && !full;
    assign pop_ok     = pop && !empty;
    assign next_count = CNT_W'(count + CNT_W'(push_ok) - CNT_W'(pop_ok));
    assign head       = mem[rd_ptr];

    // ==========================================
    // storage
    always_ff @(posedge sys_clk) begin
        if (push_ok) begin
            mem[wr_ptr] <= push_data;
        end
    end

    // ==========================================
    // pointers and registered flags
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            empty    <= 1'b1;
            at_level <= 1'b0;
            full     <= 1'b0;
        end else begin
            if (push_ok) begin
                wr_ptr <= PTR_W'((DEPTH'(wr_ptr) + 1) % DEPTH);
            end
            if (pop_ok) begin
                rd_ptr <= PTR_W'((DEPTH'(rd_ptr) + 1) % DEPTH);
            end
            count    <= next_count;
            empty    <= next_count == '0;
            at_level <= next_count >= CNT_W'(LEVEL);
            full     <= next_count == CNT_W'(DEPTH);
        end
    end
endmodule : word_fifo
`default_nettype wire

// [hw/label_table.sv]
`timescale 1ns/1ps
`default_nettype none
module label_table
    import arinc_map_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int PTR_W = 3
) (
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire logic               clear,
    input  wire logic               wr,
    input  wire logic [LABEL_W-1:0] wr_label,
    input  wire logic               rd,
    output logic      [LABEL_W-1:0] rd_label,
    input  wire logic [LABEL_W-1:0] probe,
    output logic                    hit,
    output logic      [PTR_W-1:0]   wr_ptr,
    output logic      [PTR_W-1:0]   rd_ptr
);
    logic [LABEL_W-1:0] mem [DEPTH];
    logic [PTR_W:0]     fill;

    assign rd_label = mem[rd_ptr];

    // ==========================================
    // storage, addressed by own counters only
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= LABEL_RST;
            end
        end else if (wr) begin
            mem[wr_ptr] <= wr_label; // RL17
        end
    end

    // ==========================================
    // counters
    always_ff @(posedge sys_clk) begin
        if (srst || clear) begin
            wr_ptr <= '0; // RL14
            rd_ptr <= '0; // RL14
            fill   <= '0;
        end else begin
            if (wr) begin
                wr_ptr <= PTR_W'(wr_ptr + 1'b1); // RL18
                if (fill != (PTR_W + 1)'(DEPTH)) begin
                    fill <= (PTR_W + 1)'(fill + 1'b1);
                end
            end
            if (rd) begin
                rd_ptr <= PTR_W'(rd_ptr + 1'b1); // RL19
            end
        end
    end

    // ==========================================
    // compare incoming label with loaded entries
    always_comb begin
        hit = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if ((PTR_W + 1)'(i) < fill && mem[i] == probe) begin
                hit = 1'b1; // RL21
            end
        end
    end
endmodule : label_table
`default_nettype wire

// [hw/arinc_channel_register_map.sv]
// Function
// [RL1] 8-bit bus: address bits 1:0 pick byte
// [RL2] 16-bit bus: 00 lower, 10 upper half
// [RL3] 32-bit bus: whole word per access
// [RL4] address bits 3:2 pick register
// [RL5] address bit 4: receive or transmit block
// [RL6] address bits 8:5 pick one of sixteen channels
// [RL7] receive: data, control, status, label memory
// [RL8] transmit: data, control, status, unused
// [RL9] control bit 0 selects low line rate
// [RL10] receive bit 1 enables label matching
// [RL11] bit 2 makes word bit 32 parity
// [RL12] bit 3 selects odd or even parity
// [RL13] bit 4 enables SDI match to bits 5,6
// [RL14] receive bit 7 resets label pointers
// [RL15] status: empty, level reached, full
// [RL16] transmit bit 1 enables loopback
// [RL17] label addresses come from internal counters
// [RL18] label write counter steps per write
// [RL19] label read counter steps per read
// [RL20] host resets pointers before loading labels
// [RL21] incoming label compared against label memory
// [RL22] active low strobes sampled on clock
// [RL23] host holds strobe while wait is asserted
// [RL24] data read pops, data write appends
// [RL25] unused or undefined bits read zero
`timescale 1ns/1ps
`default_nettype none
module arinc_channel_register_map
    import arinc_map_pkg::*;
#(
    parameter int CHANNELS    = 16,
    parameter int DATA_W      = 32,
    parameter int FIFO_DEPTH  = 8,
    parameter int FIFO_LEVEL  = 4,
    parameter int LABEL_DEPTH = 8
) (
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    input  wire logic                       cpu_ren_n,
    input  wire logic                       cpu_wen_n,
    input  wire logic [ADDR_W-1:0]          cpu_add,
    input  wire logic [DATA_W-1:0]          cpu_din,
    output logic      [DATA_W-1:0]          cpu_dout,
    output logic                            cpu_wait,
    input  wire logic [CHANNELS-1:0]        rx_in_valid,
    input  wire logic [CHANNELS*WORD_W-1:0] rx_in_word,
    input  wire logic [CHANNELS-1:0]        tx_out_ready,
    output logic      [CHANNELS-1:0]        tx_out_valid,
    output logic      [CHANNELS*WORD_W-1:0] tx_out_word,
    output logic      [CHANNELS-1:0]        rx_rate_low,
    output logic      [CHANNELS-1:0]        tx_rate_low,
    output logic      [CHANNELS-1:0]        tx_loopback,
    output logic      [CHANNELS-1:0]        tx_parity_en,
    output logic      [CHANNELS-1:0]        tx_parity_even
);
    localparam int LPTR_W = $clog2(LABEL_DEPTH);

    access_state_type     state;
    logic [CHAN_W-1:0]    sel_ch;
    logic                 sel_tx;
    logic [1:0]           sel_reg;
    logic [1:0]           lane_shift;
    logic                 first_lane;
    logic                 last_lane;
    logic                 take;
    logic                 take_rd;
    logic                 take_wr;
    logic [WORD_W-1:0]    wide_din;
    logic [WORD_W-1:0]    lane_mask;
    logic [WORD_W-1:0]    merged_word;
    logic [WORD_W-1:0]    tx_assembly;
    logic [WORD_W-1:0]    reg_value;
    logic [WORD_W-1:0]    read_lane;

    logic [RX_CTRL_W-1:0] rx_control [CHANNELS];
    logic [TX_CTRL_W-1:0] tx_control [CHANNELS];
    logic [WORD_W-1:0]    rx_head    [CHANNELS];
    logic [WORD_W-1:0]    tx_head    [CHANNELS];
    logic [LABEL_W-1:0]   label_rd   [CHANNELS];
    logic [LPTR_W-1:0]    lbl_wr_ptr [CHANNELS];
    logic [LPTR_W-1:0]    lbl_rd_ptr [CHANNELS];
    logic [CHANNELS-1:0]  rx_empty;
    logic [CHANNELS-1:0]  rx_level;
    logic [CHANNELS-1:0]  rx_full;
    logic [CHANNELS-1:0]  tx_empty;
    logic [CHANNELS-1:0]  tx_level;
    logic [CHANNELS-1:0]  tx_full;
    logic [CHANNELS-1:0]  rx_push;
    logic [CHANNELS-1:0]  tx_pop;

    // ==========================================
    // address decode and byte lanes
    assign sel_ch  = cpu_add[CHAN_LSB +: CHAN_W]; // RL6
    assign sel_tx  = cpu_add[BLOCK_BIT]; // RL5
    assign sel_reg = cpu_add[REG_IDX_LSB +: 2]; // RL4

    always_comb begin
        if (DATA_W == 32) begin
            lane_shift = 2'h0; // RL3
        end else if (DATA_W == 16) begin
            lane_shift = {cpu_add[1], 1'b0}; // RL2
        end else begin
            lane_shift = cpu_add[1:0]; // RL1
        end
    end

    assign first_lane  = lane_shift == 2'h0;
    assign last_lane   = (DATA_W == 32) || (DATA_W == 16 && cpu_add[1])
                      || (DATA_W == 8 && cpu_add[1:0] == 2'h3);
    assign wide_din    = WORD_W'(cpu_din) << {lane_shift, 3'h0};
    assign lane_mask   = WORD_W'({DATA_W{1'b1}}) << {lane_shift, 3'h0};
    assign merged_word = (tx_assembly & ~lane_mask) | (wide_din & lane_mask);

    // strobes are sampled once per access; read wins a clash
    assign take    = state == ACC_IDLE && (!cpu_ren_n || !cpu_wen_n); // RL22
    assign take_rd = take && !cpu_ren_n;
    assign take_wr = take && cpu_ren_n;

    // ==========================================
    // access sequence and wait
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state    <= ACC_IDLE;
            cpu_wait <= 1'b0;
        end else begin
            case (state)
                ACC_IDLE: begin
                    if (take) begin
                        state    <= ACC_HOLD;
                        cpu_wait <= 1'b1; // RL23
                    end
                end
                ACC_HOLD: begin
                    state    <= ACC_DONE;
                    cpu_wait <= 1'b0;
                end
                ACC_DONE: begin
                    if (cpu_ren_n && cpu_wen_n) begin
                        state <= ACC_IDLE; // RL23
                    end
                end
                default: begin
                    state    <= ACC_IDLE;
                    cpu_wait <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // read data select
    always_comb begin
        reg_value = '0; // RL25
        if (sel_tx == BLOCK_RX) begin
            if (sel_reg == REG_DATA) begin
                reg_value = rx_head[sel_ch]; // RL7
            end else if (sel_reg == REG_CONTROL) begin
                reg_value = WORD_W'(rx_control[sel_ch]);
            end else if (sel_reg == REG_STATUS) begin
                reg_value = WORD_W'({rx_full[sel_ch], rx_level[sel_ch], rx_empty[sel_ch]}); // RL15
            end else begin
                reg_value = WORD_W'(label_rd[sel_ch]);
            end
        end else begin
            if (sel_reg == REG_CONTROL) begin
                reg_value = WORD_W'(tx_control[sel_ch]); // RL8
            end else if (sel_reg == REG_STATUS) begin
                reg_value = WORD_W'({tx_full[sel_ch], tx_level[sel_ch], tx_empty[sel_ch]}); // RL15
            end
        end
        read_lane = reg_value >> {lane_shift, 3'h0}; // RL1 RL2
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpu_dout <= '0;
        end else if (take_rd) begin
            cpu_dout <= read_lane[DATA_W-1:0];
        end
    end

    // ==========================================
    // transmit word assembly over narrow bus
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_assembly <= WORD_RST;
        end else if (take_wr && sel_tx == BLOCK_TX && sel_reg == REG_DATA) begin
            tx_assembly <= merged_word;
        end
    end

    // ==========================================
    // per channel
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        logic [WORD_W-1:0] in_word;
        logic              hit;
        logic              label_ok;
        logic              sdi_ok;
        logic              parity_ok;
        logic              here;

        assign here    = sel_ch == CHAN_W'(ch);
        assign in_word = rx_in_word[ch*WORD_W +: WORD_W];

        always_ff @(posedge sys_clk) begin
            if (srst) begin
                rx_control[ch] <= RX_CTRL_RST;
                tx_control[ch] <= TX_CTRL_RST;
            end else if (take_wr && here && first_lane && sel_reg == REG_CONTROL) begin
                if (sel_tx == BLOCK_RX) begin
                    rx_control[ch] <= cpu_din[RX_CTRL_W-1:0];
                end else begin
                    tx_control[ch] <= cpu_din[TX_CTRL_W-1:0];
                end
            end
        end

        assign rx_rate_low[ch]    = rx_control[ch][CTL_RATE]; // RL9
        assign tx_rate_low[ch]    = tx_control[ch][CTL_RATE]; // RL9
        assign tx_loopback[ch]    = tx_control[ch][CTL_LOOPBACK]; // RL16
        assign tx_parity_en[ch]   = tx_control[ch][CTL_PAR_EN]; // RL11
        assign tx_parity_even[ch] = tx_control[ch][CTL_PAR_EVEN]; // RL12

        // acceptance filter on incoming words
        assign label_ok  = !rx_control[ch][CTL_LBL_CMP] || hit; // RL10
        assign sdi_ok    = !rx_control[ch][CTL_SDI_EN]
                        || in_word[SDI_LSB +: SDI_W] == rx_control[ch][CTL_SDI_LSB +: SDI_W]; // RL13
        assign parity_ok = !rx_control[ch][CTL_PAR_EN]
                        || ((^in_word) ^ rx_control[ch][CTL_PAR_EVEN]); // RL11 RL12
        assign rx_push[ch] = rx_in_valid[ch] && label_ok && sdi_ok && parity_ok;

        label_table #(
            .DEPTH (LABEL_DEPTH),
            .PTR_W (LPTR_W)
        ) u_labels (
            .sys_clk  (sys_clk),
            .srst     (srst),
            .clear    (take_wr && here && first_lane && sel_tx == BLOCK_RX
                       && sel_reg == REG_CONTROL && cpu_din[CTL_RELOAD]), // RL14
            .wr       (take_wr && here && first_lane && sel_tx == BLOCK_RX && sel_reg == REG_LABEL), // RL18
            .wr_label (cpu_din[LABEL_W-1:0]),
            .rd       (take_rd && here && first_lane && sel_tx == BLOCK_RX && sel_reg == REG_LABEL), // RL19
            .rd_label (label_rd[ch]),
            .probe    (in_word[LABEL_LSB +: LABEL_W]), // RL21
            .hit      (hit),
            .wr_ptr   (lbl_wr_ptr[ch]),
            .rd_ptr   (lbl_rd_ptr[ch])
        );

        word_fifo #(
            .WIDTH (WORD_W),
            .DEPTH (FIFO_DEPTH),
            .LEVEL (FIFO_LEVEL)
        ) u_rx_fifo (
            .sys_clk   (sys_clk),
            .srst      (srst),
            .push      (rx_push[ch]),
            .push_data (in_word),
            .pop       (take_rd && here && last_lane && sel_tx == BLOCK_RX && sel_reg == REG_DATA), // RL24
            .head      (rx_head[ch]),
            .empty     (rx_empty[ch]),
            .at_level  (rx_level[ch]),
            .full      (rx_full[ch])
        );

        word_fifo #(
            .WIDTH (WORD_W),
            .DEPTH (FIFO_DEPTH),
            .LEVEL (FIFO_LEVEL)
        ) u_tx_fifo (
            .sys_clk   (sys_clk),
            .srst      (srst),
            .push      (take_wr && here && last_lane && sel_tx == BLOCK_TX && sel_reg == REG_DATA), // RL24
            .push_data (merged_word),
            .pop       (tx_pop[ch]),
            .head      (tx_head[ch]),
            .empty     (tx_empty[ch]),
            .at_level  (tx_level[ch]),
            .full      (tx_full[ch])
        );

        // output stage toward the serialiser
        assign tx_pop[ch] = !tx_empty[ch] && (!tx_out_valid[ch] || tx_out_ready[ch]);

        always_ff @(posedge sys_clk) begin
            if (srst) begin
                tx_out_valid[ch]                   <= 1'b0;
                tx_out_word[ch*WORD_W +: WORD_W]   <= WORD_RST;
            end else if (tx_pop[ch]) begin
                tx_out_valid[ch]                   <= 1'b1;
                tx_out_word[ch*WORD_W +: WORD_W]   <= tx_head[ch];
            end else if (tx_out_ready[ch]) begin
                tx_out_valid[ch]                   <= 1'b0;
            end
        end

        sdi_reject_a: assert property (@(posedge sys_clk) disable iff (srst) // RL13
            rx_in_valid[ch] && rx_control[ch][CTL_SDI_EN]
            && in_word[SDI_LSB +: SDI_W] != rx_control[ch][CTL_SDI_LSB +: SDI_W] |-> !rx_push[ch])
            else $error("word with wrong sdi accepted");
    end

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    wait_pulse_a: assert property (take |=> cpu_wait ##1 !cpu_wait) // RL23
        else $error("wait not a single cycle after access");
    no_retake_a: assert property (take |=> !take ##1 !take) // RL22
        else $error("access taken twice");
    status_read_a: assert property (take_rd && sel_tx == BLOCK_RX && sel_reg == REG_STATUS && first_lane // RL15
        |=> cpu_dout[STAT_W-1:0] == $past({rx_full[sel_ch], rx_level[sel_ch], rx_empty[sel_ch]}))
        else $error("status read mismatch");
    ctrl_write_a: assert property (take_wr && sel_tx == BLOCK_RX && sel_reg == REG_CONTROL && first_lane // RL7
        |=> rx_control[$past(sel_ch)] == $past(cpu_din[RX_CTRL_W-1:0]))
        else $error("control write lost");
    tx_unused_a: assert property (take_rd && sel_tx == BLOCK_TX && sel_reg == REG_LABEL // RL25
        |=> cpu_dout == '0)
        else $error("unused index read nonzero");
    label_wr_a: assert property (take_wr && sel_tx == BLOCK_RX && sel_reg == REG_LABEL && first_lane // RL18
        |=> lbl_wr_ptr[$past(sel_ch)] == LPTR_W'($past(lbl_wr_ptr[sel_ch]) + 1'b1))
        else $error("label write counter did not step");
    label_rd_a: assert property (take_rd && sel_tx == BLOCK_RX && sel_reg == REG_LABEL && first_lane // RL19
        |=> lbl_rd_ptr[$past(sel_ch)] == LPTR_W'($past(lbl_rd_ptr[sel_ch]) + 1'b1))
        else $error("label read counter did not step");
    label_clear_a: assert property (take_wr && sel_tx == BLOCK_RX && sel_reg == REG_CONTROL // RL14
        && first_lane && cpu_din[CTL_RELOAD]
        |=> lbl_wr_ptr[$past(sel_ch)] == '0 && lbl_rd_ptr[$past(sel_ch)] == '0)
        else $error("label pointers not cleared");
    tx_append_a: assert property (take_wr && sel_tx == BLOCK_TX && sel_reg == REG_DATA && last_lane // RL24
        |=> !tx_empty[$past(sel_ch)] || tx_out_valid[$past(sel_ch)])
        else $error("transmit word not appended");

    cover property (take_wr && sel_tx == BLOCK_TX && sel_reg == REG_DATA && last_lane);
    cover property (take_rd && sel_tx == BLOCK_RX && sel_reg == REG_DATA && !rx_empty[sel_ch]);
    cover property (take_wr && sel_tx == BLOCK_RX && sel_reg == REG_LABEL);
    cover property (|rx_push);
endmodule : arinc_channel_register_map
`default_nettype wire

// [dv/host_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
    import arinc_map_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              cpu_wait,
    input  wire logic [31:0]       cpu_dout,
    output logic                   cpu_ren_n,
    output logic                   cpu_wen_n,
    output logic      [ADDR_W-1:0] cpu_add,
    output logic      [31:0]       cpu_din
);
    // ==========================================
    // one strobed access, held until wait seen
    initial begin
        cpu_ren_n = 1'b1;
        cpu_wen_n = 1'b1;
        cpu_add   = '0;
        cpu_din   = '0;
    end
    task automatic access(input logic rd, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(negedge sys_clk);
        cpu_add = a;
        cpu_din = d;
        if (rd) cpu_ren_n = 1'b0;
        else cpu_wen_n = 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (cpu_wait !== 1'b1 && n < 16);
        q = (n < 16) ? cpu_dout : 32'hDEAD_0BAD;
        @(negedge sys_clk);
        cpu_ren_n = 1'b1;
        cpu_wen_n = 1'b1;
        cpu_add   = ~a;
        cpu_din   = ~d;
    endtask : access
endmodule : host_bus_model
`default_nettype wire

// [dv/tb_arinc_channel_register_map.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_arinc_channel_register_map;
    import arinc_map_pkg::*;
    logic         sys_clk, srst, cpu_ren_n, cpu_wen_n, cpu_wait;
    logic [8:0]   cpu_add;
    logic [31:0]  cpu_din, cpu_dout;
    logic [15:0]  rx_in_valid, tx_out_ready, tx_out_valid, rx_rate_low, tx_rate_low;
    logic [15:0]  tx_loopback, tx_parity_en, tx_parity_even;
    logic [511:0] rx_in_word, tx_out_word;
    int           err_count, cmp_count;
    arinc_channel_register_map i_arinc_channel_register_map(.sys_clk, .srst, .cpu_ren_n, .cpu_wen_n,
        .cpu_add, .cpu_din, .cpu_dout, .cpu_wait, .rx_in_valid, .rx_in_word, .tx_out_ready,
        .tx_out_valid, .tx_out_word, .rx_rate_low, .tx_rate_low, .tx_loopback, .tx_parity_en,
        .tx_parity_even);
    host_bus_model i_host_bus_model(.sys_clk, .cpu_wait, .cpu_dout, .cpu_ren_n, .cpu_wen_n,
        .cpu_add, .cpu_din);
    // ==========================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [8:0] ad(input int ch, input logic tx, input logic [1:0] idx);
        return {4'(ch), tx, idx, 2'h0};
    endfunction : ad
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host_bus_model.access(1'b0, a, d, q);
        if (q === 32'hDEAD_0BAD) chk(q, 32'h0);
    endtask : wr
    task automatic rd_chk(input logic [8:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_host_bus_model.access(1'b1, a, 32'h0, q);
        chk(q, e);
    endtask : rd_chk
    task automatic push(input int ch, input logic [31:0] w);
        @(negedge sys_clk);
        rx_in_word[ch*32+:32] = w;
        rx_in_valid[ch] = 1'b1;
        @(negedge sys_clk);
        rx_in_valid[ch] = 1'b0;
        rx_in_word[ch*32+:32] = ~w;
        repeat (2) @(negedge sys_clk);
    endtask : push
    // ==========================================
    // scenarios
    task automatic test_reset;
        rd_chk(ad(0, 0, REG_CONTROL), 32'h0);
        rd_chk(ad(0, 0, REG_STATUS), 32'h1);
        rd_chk(ad(0, 1, REG_STATUS), 32'h1);
        rd_chk(ad(0, 1, REG_LABEL), 32'h0);
    endtask : test_reset
    task automatic test_control;
        for (int ch = 0; ch < 16; ch += 15) begin
            wr(ad(ch, 0, REG_CONTROL), 32'hFFFF_FF65);
            rd_chk(ad(ch, 0, REG_CONTROL), 32'h65);
            wr(ad(ch, 1, REG_CONTROL), 32'hFFFF_FFFB);
            rd_chk(ad(ch, 1, REG_CONTROL), 32'h0B);
            chk({tx_parity_even[ch], tx_parity_en[ch], tx_loopback[ch], tx_rate_low[ch]}, 32'hB);
        end
        chk({rx_rate_low, tx_loopback}, 32'h8001_8001);
        wr(ad(0, 1, REG_CONTROL), 32'h0C);
        chk({tx_parity_even[0], tx_parity_en[0], tx_loopback[0], tx_rate_low[0]}, 32'hC);
        wr(ad(15, 1, 2'h3), 32'hFFFF_FFFF);
        rd_chk(ad(15, 1, 2'h3), 32'h0);
    endtask : test_control
    task automatic test_tx;
        wr(ad(3, 1, REG_DATA), 32'hA5C3_0F81);
        wr(ad(3, 1, REG_DATA), 32'h5A3C_F07E);
        chk(tx_out_valid, 32'h0008);
        chk(tx_out_word[3*32+:32], 32'hA5C3_0F81);
        rd_chk(ad(3, 1, REG_STATUS), 32'h0);
        tx_out_ready[3] = 1'b1;
        @(negedge sys_clk);
        chk(tx_out_word[3*32+:32], 32'h5A3C_F07E);
        repeat (3) @(negedge sys_clk);
        tx_out_ready[3] = 1'b0;
        chk(tx_out_valid, 32'h0);
        rd_chk(ad(3, 1, REG_STATUS), 32'h1);
    endtask : test_tx
    task automatic test_filters;
        logic [7:0]  ctl [9] = '{8'h02, 8'h02, 8'h00, 8'h30, 8'h30, 8'h04, 8'h04, 8'h0C, 8'h0C};
        logic [31:0] wd [9] = '{32'h42, 32'h55, 32'h55, 32'h100, 32'h200, 32'h1, 32'h3, 32'h3, 32'h1};
        logic        ok [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        wr(ad(1, 0, REG_CONTROL), 32'h82);
        wr(ad(1, 0, REG_LABEL), 32'h55);
        rd_chk(ad(1, 0, REG_LABEL), 32'h55);
        wr(ad(1, 0, REG_CONTROL), 32'h82);
        wr(ad(1, 0, REG_LABEL), 32'h31);
        wr(ad(1, 0, REG_LABEL), 32'h42);
        rd_chk(ad(1, 0, REG_LABEL), 32'h31);
        rd_chk(ad(1, 0, REG_LABEL), 32'h42);
        for (int i = 0; i < 9; i++) begin
            wr(ad(1, 0, REG_CONTROL), {24'h0, ctl[i]});
            push(1, wd[i]);
            rd_chk(ad(1, 0, REG_STATUS), {31'h0, !ok[i]});
            if (ok[i]) rd_chk(ad(1, 0, REG_DATA), wd[i]);
        end
    endtask : test_filters
    task automatic test_full;
        for (int i = 0; i < 9; i++) begin
            push(2, 32'(i));
            if (i == 3) rd_chk(ad(2, 0, REG_STATUS), 32'h2);
        end
        rd_chk(ad(2, 0, REG_STATUS), 32'h6);
        rd_chk(ad(2, 0, REG_DATA), 32'h0);
        rd_chk(ad(2, 0, REG_DATA), 32'h1);
    endtask : test_full
    // ==========================================
    // run control
    task automatic tally_and_finish;
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #400us;
        err_count++;
        tally_and_finish();
    end
    initial begin
        srst = 1'b1;
        rx_in_valid = '0;
        rx_in_word = '0;
        tx_out_ready = '0;
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        test_reset();
        test_control();
        test_tx();
        test_filters();
        test_full();
        tally_and_finish();
    end
endmodule : tb_arinc_channel_register_map
`default_nettype wire
